// ==== common/rx_cfg_params.svh ====
/*
 receiver configuration bank: offsets, field positions, reset values and timing counts.
 assumes 32-bit axi4-lite register access and a 250 MHz clock.
*/
// Behaviour
// - single channel: choice bit picks enabled one
// - both enabled, manual: choice picks framing channel
// - bit 6: peak detector or mixer
// - lowpass and zero codes forwarded unchanged
// - low power receiver bit
// - lf split or differential lf
// - lf signal on receiver input
// - agc enable and agc period mode
// - agc preset or reset algorithm
// - auto squelch: start delayed, stop on mask
// - pm mixer clock, single-ended forces internal
// - am first gain code, code 7 boosts
// - pm first gain code, same coding
// - clip first and second stage outputs
// - peer mode forces gain and window
// - defaults at reset and restore command
// - three rw registers from index 0ah
`ifndef RX_CFG_PARAMS_SVH
`define RX_CFG_PARAMS_SVH
// register indices; byte address is four times the index
`define CH_FILT_IDX 6'h0a
`define AGC_SQ_IDX 6'h0b
`define GAIN1_IDX 6'h0c
`define AXIL_AW 8
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
// reset values
`define CH_FILT_RST 8'h00
`define AGC_SQ_RST 8'h1a
`define GAIN1_RST 8'hd8
// channel and filter register fields
`define CHOICE_BIT 7
`define AMD_MIX_BIT 6
`define LOWPASS_LSB 3
`define ZERO_LSB 0
// agc and squelch register fields
`define LOWPWR_BIT 7
`define LFSPLIT_BIT 6
`define LFEN_BIT 5
`define AGCEN_BIT 4
`define AGCMODE_BIT 3
`define AGCALG_BIT 2
`define SQAUTO_BIT 1
`define PMIX_BIT 0
// first stage gain register fields
`define AMGAIN_LSB 5
`define PMGAIN_LSB 2
`define CLIP_BIT 1
`define PEERFORCE_BIT 0
`define GAIN_BOOST_CODE 3'h7
// squelch start delay after end of transmit
`define SQ_DELAY_NS 18880
`define CLK_PERIOD_NS 4
`define SQ_DELAY_CYC ((`SQ_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SQ_CNT_W 13
`endif

// ==== common/rx_cfg_pkg.sv ====
/*
 types for the receiver configuration bank.
 assumes the params header is on the include path.
*/
package rx_cfg_pkg;
`include "rx_cfg_params.svh"
    typedef struct packed {
        logic [`AXIL_AW-1:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [`AXIL_AW-1:0] araddr;
        logic arvalid;
        logic rready;
    } axil_req_t;
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axil_rsp_t;
    typedef enum logic [1:0] {
        SEL_NONE = 2'b00,
        SEL_CH = 2'b01,
        SEL_AGC = 2'b10,
        SEL_GAIN = 2'b11
    } reg_sel_t;
    typedef enum logic [1:0] {
        SQ_IDLE = 2'b00,
        SQ_WAIT = 2'b01,
        SQ_ON = 2'b10
    } sq_state_t;
    typedef struct packed {
        logic am_en;
        logic pm_en;
        logic framing_pm;
        logic am_mixer;
        logic [2:0] lowpass;
        logic [2:0] zero;
        logic low_power;
        logic lf_split;
        logic lf_input_en;
        logic agc_en;
        logic agc_full_period;
        logic agc_reset_alg;
        logic pm_mix_internal;
        logic [2:0] am_gain;
        logic am_boost;
        logic [2:0] pm_gain;
        logic pm_boost;
        logic clip;
        logic peer_force;
        logic squelch;
    } rx_analog_t;
    // word decode; byte address is four times the index
    function automatic reg_sel_t reg_decode(input logic [`AXIL_AW-1:0] addr);
        reg_decode = SEL_NONE;
        if (addr[1:0] == 2'b00)
        begin
            case (addr[`AXIL_AW-1:2])
                `CH_FILT_IDX: reg_decode = SEL_CH;
                `AGC_SQ_IDX: reg_decode = SEL_AGC;
                `GAIN1_IDX: reg_decode = SEL_GAIN;
                default: reg_decode = SEL_NONE;
            endcase
        end
    endfunction
endpackage

// ==== design/rx_cfg_axil_slave.sv ====
/*
 axi4-lite slave front end for the receiver configuration bank.
 assumes the owner decodes the address and returns read data combinationally.
*/
`timescale 1ns/1ps
`include "rx_cfg_params.svh"
module rx_cfg_axil_slave (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // bus
    input wire rx_cfg_pkg::axil_req_t req_i,
    output rx_cfg_pkg::axil_rsp_t rsp_o,
    // register side
    output logic wr_en_o,
    output logic [`AXIL_AW-1:0] wr_addr_o,
    output logic [7:0] wr_data_o,
    output logic [`AXIL_AW-1:0] rd_addr_o,
    input wire logic [7:0] rd_data_i
);
    import rx_cfg_pkg::*;
    typedef struct packed {
        logic aw_got;
        logic [`AXIL_AW-1:0] aw_addr;
        logic w_got;
        logic [7:0] w_data;
        logic w_lane;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
    } slv_state_t;
    slv_state_t st_ff;
    slv_state_t nxt_st;
    logic hit;
    // handshake, write commit and read capture
    always_comb
    begin
        nxt_st = st_ff;
        hit = reg_decode(st_ff.aw_addr) != SEL_NONE;
        wr_en_o = 1'b0;
        if (req_i.awvalid && !st_ff.aw_got && !st_ff.bvalid)
        begin
            nxt_st.aw_got = 1'b1;
            nxt_st.aw_addr = req_i.awaddr;
        end
        if (req_i.wvalid && !st_ff.w_got && !st_ff.bvalid)
        begin
            nxt_st.w_got = 1'b1;
            nxt_st.w_data = req_i.wdata[7:0];
            nxt_st.w_lane = req_i.wstrb[0];
        end
        if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid)
        begin
            wr_en_o = hit && st_ff.w_lane;
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = hit ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (st_ff.bvalid && req_i.bready)
        begin
            nxt_st.bvalid = 1'b0;
        end
        if (st_ff.rvalid && req_i.rready)
        begin
            nxt_st.rvalid = 1'b0;
        end
        if (req_i.arvalid && !st_ff.rvalid)
        begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata = rd_data_i;
            nxt_st.rresp = (reg_decode(req_i.araddr) != SEL_NONE) ? `RESP_OKAY : `RESP_SLVERR;
        end
    end
    // state register
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end
    // port drive
    always_comb
    begin
        rsp_o = '0;
        rsp_o.awready = !st_ff.aw_got && !st_ff.bvalid;
        rsp_o.wready = !st_ff.w_got && !st_ff.bvalid;
        rsp_o.bvalid = st_ff.bvalid;
        rsp_o.bresp = st_ff.bresp;
        rsp_o.arready = !st_ff.rvalid;
        rsp_o.rvalid = st_ff.rvalid;
        rsp_o.rdata = {24'h000000, st_ff.rdata};
        rsp_o.rresp = st_ff.rresp;
    end
    assign wr_addr_o = st_ff.aw_addr;
    assign wr_data_o = st_ff.w_data;
    assign rd_addr_o = req_i.araddr;
endmodule // rx_cfg_axil_slave

// ==== design/receiver_config_regs.sv ====
/*
 receiver configuration bank: three rw registers steering the analog receiver,
 plus the automatic squelch sequencer.
 assumes all control inputs come from logic on clk_i; software on axi4-lite.
*/
`timescale 1ns/1ps
`include "rx_cfg_params.svh"
module receiver_config_regs #(
    parameter int SQ_DELAY_CYC = `SQ_DELAY_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // register bus
    input wire rx_cfg_pkg::axil_req_t axil_req_i,
    output rx_cfg_pkg::axil_rsp_t axil_rsp_o,
    // direct command
    input wire logic restore_defaults_i,
    // operation control and receive state
    input wire logic single_channel_i,
    input wire logic manual_select_i,
    input wire logic auto_pick_pm_i,
    input wire logic single_ended_i,
    input wire logic tx_end_i,
    input wire logic mask_timer_done_i,
    // analog receiver settings
    output rx_cfg_pkg::rx_analog_t analog_o
);
    import rx_cfg_pkg::*;

    typedef struct packed {
        logic [7:0] ch_filt;
        logic [7:0] agc_sq;
        logic [7:0] gain1;
        sq_state_t sq_state;
        logic [`SQ_CNT_W-1:0] sq_cnt;
        rx_analog_t ana;
    } cfg_state_t;

    cfg_state_t st_ff;
    cfg_state_t nxt_st;

    logic wr_en;
    logic [`AXIL_AW-1:0] wr_addr;
    logic [7:0] wr_data;
    logic [`AXIL_AW-1:0] rd_addr;
    logic [7:0] rd_data;
    reg_sel_t wr_sel;

    // first stage gain code 7 means boost, 1..6 reduce
    function automatic logic gain_is_boost(input logic [2:0] code);
        gain_is_boost = (code == `GAIN_BOOST_CODE);
    endfunction

    // bus front end
    rx_cfg_axil_slave u_slave (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .req_i(axil_req_i),
        .rsp_o(axil_rsp_o),
        .wr_en_o(wr_en),
        .wr_addr_o(wr_addr),
        .wr_data_o(wr_data),
        .rd_addr_o(rd_addr),
        .rd_data_i(rd_data)
    );

    // read mux, every bit reads back as stored
    always_comb
    begin
        case (reg_decode(rd_addr))
            SEL_CH: rd_data = st_ff.ch_filt;
            SEL_AGC: rd_data = st_ff.agc_sq;
            SEL_GAIN: rd_data = st_ff.gain1;
            default: rd_data = 8'h00;
        endcase
    end

    assign wr_sel = reg_decode(wr_addr);

    // next state: registers, squelch sequencer, analog settings
    always_comb
    begin
        nxt_st = st_ff;
        // register writes take effect at once
        if (wr_en)
        begin
            case (wr_sel)
                SEL_CH: nxt_st.ch_filt = wr_data;
                SEL_AGC: nxt_st.agc_sq = wr_data;
                SEL_GAIN: nxt_st.gain1 = wr_data;
                default: nxt_st.ch_filt = st_ff.ch_filt;
            endcase
        end
        // restore command overrides a same-cycle write
        if (restore_defaults_i)
        begin
            nxt_st.ch_filt = `CH_FILT_RST;
            nxt_st.agc_sq = `AGC_SQ_RST;
            nxt_st.gain1 = `GAIN1_RST;
        end

        // squelch: delayed start after tx end, stop on mask timer
        case (st_ff.sq_state)
            SQ_IDLE:
            begin
                nxt_st.sq_cnt = '0;
                if (tx_end_i && st_ff.agc_sq[`SQAUTO_BIT])
                begin
                    nxt_st.sq_state = SQ_WAIT;
                end
            end
            SQ_WAIT:
            begin
                nxt_st.sq_cnt = st_ff.sq_cnt + `SQ_CNT_W'(1);
                if (mask_timer_done_i)
                begin
                    nxt_st.sq_state = SQ_IDLE;
                end
                else if (st_ff.sq_cnt == `SQ_CNT_W'(SQ_DELAY_CYC - 1))
                begin
                    nxt_st.sq_state = SQ_ON;
                end
            end
            SQ_ON:
            begin
                nxt_st.sq_cnt = '0;
                if (mask_timer_done_i)
                begin
                    nxt_st.sq_state = SQ_IDLE;
                end
            end
            default:
            begin
                nxt_st.sq_state = SQ_IDLE;
                nxt_st.sq_cnt = '0;
            end
        endcase
        // turning automation off drops any squelch in progress
        if (!nxt_st.agc_sq[`SQAUTO_BIT])
        begin
            nxt_st.sq_state = SQ_IDLE;
            nxt_st.sq_cnt = '0;
        end

        // channel enables and framing channel
        if (single_channel_i)
        begin
            nxt_st.ana.am_en = !nxt_st.ch_filt[`CHOICE_BIT];
            nxt_st.ana.pm_en = nxt_st.ch_filt[`CHOICE_BIT];
            nxt_st.ana.framing_pm = nxt_st.ch_filt[`CHOICE_BIT];
        end
        else
        begin
            nxt_st.ana.am_en = 1'b1;
            nxt_st.ana.pm_en = 1'b1;
            nxt_st.ana.framing_pm = manual_select_i ? nxt_st.ch_filt[`CHOICE_BIT]
                                                    : auto_pick_pm_i;
        end
        // demodulator and filter codes
        nxt_st.ana.am_mixer = nxt_st.ch_filt[`AMD_MIX_BIT];
        nxt_st.ana.lowpass = nxt_st.ch_filt[`LOWPASS_LSB +: 3];
        nxt_st.ana.zero = nxt_st.ch_filt[`ZERO_LSB +: 3];
        // power, lf path and agc
        nxt_st.ana.low_power = nxt_st.agc_sq[`LOWPWR_BIT];
        nxt_st.ana.lf_split = nxt_st.agc_sq[`LFSPLIT_BIT];
        nxt_st.ana.lf_input_en = nxt_st.agc_sq[`LFEN_BIT];
        nxt_st.ana.agc_en = nxt_st.agc_sq[`AGCEN_BIT];
        nxt_st.ana.agc_full_period = nxt_st.agc_sq[`AGCMODE_BIT];
        nxt_st.ana.agc_reset_alg = nxt_st.agc_sq[`AGCALG_BIT];
        // single-ended mode always uses the internal mixer clock
        nxt_st.ana.pm_mix_internal = nxt_st.agc_sq[`PMIX_BIT] || single_ended_i;
        // first stage gains, clipping and peer force
        nxt_st.ana.am_gain = nxt_st.gain1[`AMGAIN_LSB +: 3];
        nxt_st.ana.am_boost = gain_is_boost(nxt_st.gain1[`AMGAIN_LSB +: 3]);
        nxt_st.ana.pm_gain = nxt_st.gain1[`PMGAIN_LSB +: 3];
        nxt_st.ana.pm_boost = gain_is_boost(nxt_st.gain1[`PMGAIN_LSB +: 3]);
        nxt_st.ana.clip = nxt_st.gain1[`CLIP_BIT];
        // after clearing, software restarts the receiver itself
        nxt_st.ana.peer_force = nxt_st.gain1[`PEERFORCE_BIT];
        nxt_st.ana.squelch = (nxt_st.sq_state == SQ_ON);
    end

    // state register with defaults on reset
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            st_ff <= '0;
            st_ff.ch_filt <= `CH_FILT_RST;
            st_ff.agc_sq <= `AGC_SQ_RST;
            st_ff.gain1 <= `GAIN1_RST;
            st_ff.sq_state <= SQ_IDLE;
            st_ff.ana.am_en <= 1'b1;
            st_ff.ana.pm_en <= 1'b1;
            st_ff.ana.agc_en <= 1'b1;
            st_ff.ana.agc_full_period <= 1'b1;
            st_ff.ana.am_gain <= 3'(`GAIN1_RST >> `AMGAIN_LSB);
            st_ff.ana.pm_gain <= 3'(`GAIN1_RST >> `PMGAIN_LSB);
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign analog_o = st_ff.ana;

    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    // squelch sequence pieces
    sequence sq_trigger_s;
        tx_end_i && st_ff.agc_sq[`SQAUTO_BIT] && nxt_st.agc_sq[`SQAUTO_BIT]
            && st_ff.sq_state == SQ_IDLE;
    endsequence
    sequence sq_waiting_s;
        st_ff.sq_state == SQ_WAIT && !analog_o.squelch;
    endsequence

    sq_wait_entry_a: assert property (
        sq_trigger_s |=> sq_waiting_s)
        else $error("squelch did not start its delay after tx end");

    sq_delay_exact_a: assert property (
        $rose(analog_o.squelch) |-> $past(st_ff.sq_cnt) == `SQ_CNT_W'(SQ_DELAY_CYC - 1))
        else $error("squelch started before or after the delay");

    sq_stop_mask_a: assert property (
        analog_o.squelch && mask_timer_done_i |=> !analog_o.squelch)
        else $error("squelch not stopped by mask timer");

    sq_off_auto_a: assert property (
        !st_ff.agc_sq[`SQAUTO_BIT] |-> !analog_o.squelch)
        else $error("squelch active with automation off");

    ch_single_a: assert property (
        single_channel_i |=> analog_o.pm_en == st_ff.ch_filt[`CHOICE_BIT]
            && analog_o.am_en != analog_o.pm_en)
        else $error("single channel enable does not follow choice bit");

    ch_manual_a: assert property (
        !single_channel_i && manual_select_i
            |=> analog_o.framing_pm == st_ff.ch_filt[`CHOICE_BIT])
        else $error("manual framing channel does not follow choice bit");

    restore_dflt_a: assert property (
        restore_defaults_i |=> st_ff.ch_filt == `CH_FILT_RST
            && st_ff.agc_sq == `AGC_SQ_RST && st_ff.gain1 == `GAIN1_RST)
        else $error("restore command left a register off default");

    write_store_a: assert property (
        wr_en && wr_sel == SEL_GAIN && !restore_defaults_i
            |=> st_ff.gain1 == $past(wr_data) && analog_o.am_gain == $past(wr_data[7:5]))
        else $error("gain write not stored and applied at once");

    mix_clock_a: assert property (
        single_ended_i |=> analog_o.pm_mix_internal)
        else $error("single-ended mode did not force internal mixer clock");

    boost_code_a: assert property (
        analog_o.am_boost == (analog_o.am_gain == `GAIN_BOOST_CODE)
            && analog_o.pm_boost == (analog_o.pm_gain == `GAIN_BOOST_CODE))
        else $error("boost flag disagrees with gain code");

    peer_force_a: assert property (
        analog_o.peer_force == st_ff.gain1[`PEERFORCE_BIT]
            && analog_o.clip == st_ff.gain1[`CLIP_BIT])
        else $error("peer force or clip not following register");
endmodule // receiver_config_regs

// ==== tb/receiver_config_regs_tb.sv ====
/*
 bench for the receiver configuration bank: register access, control inputs, squelch.
 assumes the params header and package are compiled first; one 250 MHz clock.
*/
`timescale 1ns/1ps
`include "rx_cfg_params.svh"
module receiver_config_regs_tb;
    import rx_cfg_pkg::*;
    localparam int SQ_CYC = 8;
    localparam logic [7:0] A_CH = {`CH_FILT_IDX, 2'b00};
    localparam logic [7:0] A_AGC = {`AGC_SQ_IDX, 2'b00};
    localparam logic [7:0] A_GAIN = {`GAIN1_IDX, 2'b00};
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    axil_req_t req = '0;
    axil_rsp_t rsp;
    rx_analog_t ana;
    logic rst_def = 1'b0;
    logic single = 1'b0;
    logic manual = 1'b0;
    logic pick = 1'b0;
    logic s_end = 1'b0;
    logic tx_end = 1'b0;
    logic mask = 1'b0;
    logic [2:0][7:0] v = {`GAIN1_RST, `AGC_SQ_RST, `CH_FILT_RST};
    logic [7:0] addr_tab [3] = '{A_CH, A_AGC, A_GAIN};
    logic [1:0] resp;
    logic [31:0] rd;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;

    // device under test, short squelch delay
    receiver_config_regs #(.SQ_DELAY_CYC(SQ_CYC)) i_dut (
        .clk_i(clk_i), .srst_i(srst_i), .axil_req_i(req), .axil_rsp_o(rsp),
        .restore_defaults_i(rst_def), .single_channel_i(single),
        .manual_select_i(manual), .auto_pick_pm_i(pick), .single_ended_i(s_end),
        .tx_end_i(tx_end), .mask_timer_done_i(mask), .analog_o(ana)
    );

    // clock
    always #2 clk_i = ~clk_i;

    // hang guard
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fail_count++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // write with both channels offered together; bready stays high
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= s;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        forever
        begin
            @(posedge clk_i);
            if (rsp.awready === 1'b1)
                req.awvalid <= 1'b0;
            if (rsp.wready === 1'b1)
                req.wvalid <= 1'b0;
            if (rsp.bvalid === 1'b1)
                break;
        end
        resp = rsp.bresp;
    endtask

    // read; rready stays high
    task automatic axi_read(input logic [7:0] a);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        forever
        begin
            @(posedge clk_i);
            if (rsp.arready === 1'b1)
                req.arvalid <= 1'b0;
            if (rsp.rvalid === 1'b1)
                break;
        end
        rd = rsp.rdata;
        resp = rsp.rresp;
    endtask

    // write all three registers, junk in the upper lanes
    task automatic set_regs(input logic [2:0][7:0] d);
        for (int k = 0; k < 3; k++)
        begin
            axi_write(addr_tab[k], {24'hffffff, d[k]}, 4'hf);
            chk(resp, `RESP_OKAY, "write resp");
        end
        v = d;
    endtask

    // analog outputs worked out from the stored fields and control levels
    task automatic chk_analog();
        rx_analog_t e;
        rx_analog_t g;
        repeat (3) @(posedge clk_i);
        g = ana;
        e = '0;
        e.am_en = !single || !v[0][7];
        e.pm_en = !single || v[0][7];
        e.framing_pm = manual ? v[0][7] : pick;
        e.am_mixer = v[0][6];
        e.lowpass = v[0][5:3];
        e.zero = v[0][2:0];
        e.low_power = v[1][7];
        e.lf_split = v[1][6];
        e.lf_input_en = v[1][5];
        e.agc_en = v[1][4];
        e.agc_full_period = v[1][3];
        e.agc_reset_alg = v[1][2];
        e.pm_mix_internal = v[1][0] || s_end;
        e.am_gain = v[2][7:5];
        e.am_boost = v[2][7:5] == `GAIN_BOOST_CODE;
        e.pm_gain = v[2][4:2];
        e.pm_boost = v[2][4:2] == `GAIN_BOOST_CODE;
        e.clip = v[2][1];
        e.peer_force = v[2][0];
        if (single)
        begin
            g.framing_pm = 1'b0;
            e.framing_pm = 1'b0;
        end
        chk(32'(g), 32'(e), "analog settings");
    endtask

    // read back all three and the analog side
    task automatic check_all();
        for (int k = 0; k < 3; k++)
        begin
            axi_read(addr_tab[k]);
            chk(rd, {24'h0, v[k]}, "read data");
            chk(resp, `RESP_OKAY, "read resp");
        end
        chk_analog();
    endtask

    task automatic t_defaults();
        check_all();
        $display("test defaults done");
    endtask

    // walking bits and every gain code
    task automatic t_fields();
        for (int i = 0; i < 8; i++)
        begin
            set_regs({i[2:0], 3'(7 - i), i[0], ~i[0], 8'h80 >> i, 8'h01 << i});
            check_all();
        end
        $display("test fields done");
    endtask

    // empty strobe, unmapped and misaligned words
    task automatic t_refused();
        logic [7:0] bad [2] = '{8'h34, 8'h29};
        axi_write(A_CH, 32'h000000ff, 4'h0);
        chk(resp, `RESP_OKAY, "empty strobe resp");
        for (int k = 0; k < 2; k++)
        begin
            axi_write(bad[k], 32'h000000ff, 4'hf);
            chk(resp, `RESP_SLVERR, "unmapped write resp");
            axi_read(bad[k]);
            chk(resp, `RESP_SLVERR, "unmapped read resp");
            chk(rd, 32'h0, "unmapped read data");
        end
        check_all();
        $display("test refused done");
    endtask

    // every mix of control levels with both channel choices
    task automatic t_channel();
        for (int j = 0; j < 32; j++)
        begin
            v[0][7] = j[4];
            v[1][0] = j[3];
            axi_write(A_CH, {24'h0, v[0]}, 4'hf);
            axi_write(A_AGC, {24'h0, v[1]}, 4'hf);
            {single, manual, pick, s_end} <= j[3:0];
            chk_analog();
        end
        $display("test channel done");
    endtask

    // one end-of-transmit pulse, then a wait of n edges
    task automatic tx_pulse(input int n);
        @(posedge clk_i);
        tx_end <= 1'b1;
        @(posedge clk_i);
        tx_end <= 1'b0;
        repeat (n) @(posedge clk_i);
    endtask

    task automatic t_squelch();
        set_regs({8'hd8, 8'h1a, 8'h00});
        // squelch rises sq_cyc edges after tx end is sampled
        tx_pulse(SQ_CYC);
        chk(ana.squelch, 1'b0, "squelch early");
        @(posedge clk_i);
        chk(ana.squelch, 1'b1, "squelch start");
        mask <= 1'b1;
        @(posedge clk_i);
        mask <= 1'b0;
        chk(ana.squelch, 1'b1, "squelch held");
        repeat (2) @(posedge clk_i);
        chk(ana.squelch, 1'b0, "squelch stop");
        // mask during the wait cancels the start
        tx_pulse(3);
        mask <= 1'b1;
        @(posedge clk_i);
        mask <= 1'b0;
        repeat (SQ_CYC + 4) @(posedge clk_i);
        chk(ana.squelch, 1'b0, "squelch cancelled");
        // clearing automation drops an active squelch
        tx_pulse(SQ_CYC + 2);
        chk(ana.squelch, 1'b1, "squelch restart");
        v[1] = 8'h18;
        axi_write(A_AGC, {24'h0, v[1]}, 4'hf);
        chk_analog();
        $display("test squelch done");
    endtask

    task automatic t_restore();
        set_regs({8'h07, 8'he5, 8'hff});
        check_all();
        // restore drops peer force; then all three registers and the analog side are read back
        rst_def <= 1'b1;
        @(posedge clk_i);
        rst_def <= 1'b0;
        v = {`GAIN1_RST, `AGC_SQ_RST, `CH_FILT_RST};
        check_all();
        $display("test restore done");
    endtask

    // main sequence
    initial
    begin
        req.bready <= 1'b1;
        req.rready <= 1'b1;
        repeat (5) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        t_defaults();
        t_fields();
        t_refused();
        t_channel();
        {single, manual, pick, s_end} <= 4'h0;
        t_squelch();
        t_restore();
        give_verdict();
    end
endmodule // receiver_config_regs_tb
